// >>> rsc_defines.svh
// offsets, field positions, reset values and timing counts of the reset source controller
`ifndef RSC_DEFINES_SVH
`define RSC_DEFINES_SVH

// ==========================================
// register map
`define RSC_FLAGS_ADDR      20'hf_ffa8
`define RSC_CFG_ADDR        20'h0_00c1
`define RSC_BIT_TRAP        7
`define RSC_BIT_WDT         4
`define RSC_BIT_SELECTABLE_SUPPLY_MONITOR        0
`define RSC_CFG_PINSEL_BIT  4
`define RSC_CFG_THR_LSB     2
`define RSC_PSW_RESET       8'h06
`define RSC_VECTOR_ADDR     16'h0000
`define RSC_ILLEGAL_OPCODE  8'hff

// ==========================================
// timing
`define RSC_CLK_HZ          50000000
`define RSC_SELECTABLE_SUPPLY_MONITOR_WAIT_NS    3010000
// any count up to the ceiling above is legal; a short one keeps power-up and brownout recovery quick
`define RSC_SELECTABLE_SUPPLY_MONITOR_WAIT_CYC   2000
`define RSC_PROC_CYC        16

`endif

// >>> rsc_pkg.sv
// types shared by the reset source controller
package rsc_pkg;

    // ==========================================
    // sequencer states
    typedef enum logic [1:0] {
        ST_RESET   = 2'b00,
        ST_SPORWT  = 2'b01,
        ST_PROC    = 2'b10,
        ST_RUN     = 2'b11
    } rsc_state_type;

    // ==========================================
    // reset source indications
    typedef struct packed {
        logic pin;
        logic wdt;
        logic trap;
        logic selectable_supply_monitor;
        logic retention;
    } rsc_src_type;

    // ==========================================
    // register state apart from the input synchronisers
    typedef struct packed {
        rsc_state_type state;
        logic [17:0]   cnt;
        logic          trap_flag;
        logic          wdt_flag;
        logic          selectable_supply_monitor_flag;
        logic          pin_rst;
        logic          powered;
        logic [7:0]    rdata;
    } rsc_regs_type;

endpackage

// >>> rsc_reset_source_controller.sv
// reset source controller: merges reset sources, sequences release, keeps source flags
`include "rsc_defines.svh"

// Functional notes
// - external pin low holds the device in reset; high releases it.
// - after reset processing the program runs on the fast internal oscillator.
// - after power-up insert at most 3.01 ms supply-monitor wait after pin release.
// - watchdog and illegal-opcode resets release by themselves.
// - port4_bit0 floats on pin or retention reset, else pulled high.
// - port12_bit5 reads low during pin reset, else pulled high.
// - reset gates CPU clock and stops all oscillators; crystal pins become inputs. Here osc_en is already on in ST_PROC, while reset still holds.
// - reset stops core and peripherals, floats other ports; supply monitor stays active.
// - after reset PC loads from vector 0000H and PROGRAM_STATUS_WORD becomes 06H.
// - during reset or wait only the PC becomes undefined.
// - flag register is read byte-wide, all flags at once.
// - a byte read of the flag register clears all flags.
// - flags: illegal opcode bit 7, watchdog bit 4, supply monitor bit 0.
// - opcode FFH raises a reset setting the illegal-opcode flag only.
// - no illegal-opcode reset while under on-chip debug.
// - watchdog reset sets its flag, others kept.
// - supply-monitor reset sets bit 0, others kept.
// - pin or retention reset clears all three flags.
// - flags are kept until supply falls to the retention limit.
// - supply monitor resets at power-on, releases above rise, reasserts below fall.
// - threshold pair selects among 4 levels from configuration byte 000C1H.
// - codes 00..11 select 4.28/4.20, 2.90/2.84, 2.57/2.52, 2.16/2.11 V.
// - the reset pin acts only when configuration bit 4 is 1.
module rsc_reset_source_controller (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // external pin and supply monitor comparators
    input  wire logic        reset_pin_n,
    input  wire logic [3:0]  vdd_above_rise,
    input  wire logic [3:0]  vdd_above_fall,
    input  wire logic        vdd_retention_ok,
    // configuration byte
    input  wire logic [7:0]  config_byte,
    // core side events
    input  wire logic        wdt_overflow,
    input  wire logic [7:0]  exec_opcode,
    input  wire logic        exec_valid,
    input  wire logic        debug_active,
    // byte read port
    input  wire logic        rd_en,
    input  wire logic        rd_bit_access,
    input  wire logic [19:0] rd_addr,
    output logic      [7:0]  rd_data,
    // reset and clock control
    output logic             sys_reset,
    output logic             cpu_clk_en,
    output logic             osc_en,
    output logic             crystal_pins_input,
    output logic             ports_float,
    output logic             pc_load,
    output logic      [15:0] pc_vector,
    output logic      [7:0]  psw_init,
    // pin controls
    output logic             port4_bit0_pullup,
    output logic             port4_bit0_oe,
    output logic             port12_bit5_pullup,
    output logic             port12_bit5_low
);

    // ==========================================
    // synchronisers for outside signals
    logic [1:0] pin_s1_r;
    logic [1:0] pin_s2_r;
    logic [3:0] rise_s1_r, rise_s2_r, fall_s1_r, fall_s2_r;
    logic [1:0] ret_s_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_s1_r  <= 2'h3;
            pin_s2_r  <= 2'h3;
            rise_s1_r <= 4'h0;
            rise_s2_r <= 4'h0;
            fall_s1_r <= 4'h0;
            fall_s2_r <= 4'h0;
            ret_s_r   <= 2'h0;
        end else begin
            pin_s1_r  <= {pin_s1_r[0], reset_pin_n};
            pin_s2_r  <= {pin_s2_r[0], pin_s1_r[1]};
            rise_s1_r <= vdd_above_rise;
            rise_s2_r <= rise_s1_r;
            fall_s1_r <= vdd_above_fall;
            fall_s2_r <= fall_s1_r;
            ret_s_r   <= {ret_s_r[0], vdd_retention_ok};
        end
    end

    // ==========================================
    // source decode
    localparam logic [17:0] SELECTABLE_SUPPLY_MONITOR_WAIT = 18'(`RSC_SELECTABLE_SUPPLY_MONITOR_WAIT_CYC);
    localparam logic [17:0] PROC_WAIT = 18'(`RSC_PROC_CYC);

    rsc_pkg::rsc_regs_type r, nxt;
    rsc_pkg::rsc_src_type  src;
    logic [1:0]            thr_sel;
    logic                  vdd_ok;
    logic                  flags_read;

    assign thr_sel = config_byte[`RSC_CFG_THR_LSB +: 2];
    // rise level while powered is clear, fall level once powered is set; hysteresis
    assign vdd_ok  = r.powered ? fall_s2_r[thr_sel] : rise_s2_r[thr_sel];

    always_comb begin
        src.pin       = config_byte[`RSC_CFG_PINSEL_BIT] && !pin_s2_r[1];
        src.wdt       = wdt_overflow && r.state == rsc_pkg::ST_RUN;
        src.trap      = exec_valid && exec_opcode == `RSC_ILLEGAL_OPCODE
                        && !debug_active && r.state == rsc_pkg::ST_RUN;
        src.selectable_supply_monitor      = !vdd_ok;
        src.retention = !ret_s_r[1];
    end

    // bit access is refused: no data, no clear
    assign flags_read = rd_en && !rd_bit_access && rd_addr == `RSC_FLAGS_ADDR;

    // ==========================================
    // next state
    always_comb begin
        nxt = r;
        nxt.rdata = 8'h00;
        if (flags_read) begin
            nxt.rdata[`RSC_BIT_TRAP] = r.trap_flag;
            nxt.rdata[`RSC_BIT_WDT]  = r.wdt_flag;
            nxt.rdata[`RSC_BIT_SELECTABLE_SUPPLY_MONITOR] = r.selectable_supply_monitor_flag;
            nxt.trap_flag = 1'b0;
            nxt.wdt_flag  = 1'b0;
            nxt.selectable_supply_monitor_flag = 1'b0;
        end
        // sets win over the read clear
        if (src.trap)
            nxt.trap_flag = 1'b1;
        if (src.wdt)
            nxt.wdt_flag = 1'b1;
        if (src.selectable_supply_monitor && r.powered)
            nxt.selectable_supply_monitor_flag = 1'b1;
        if (src.pin || src.retention) begin
            nxt.trap_flag = 1'b0;
            nxt.wdt_flag  = 1'b0;
            nxt.selectable_supply_monitor_flag = 1'b0;
        end
        nxt.pin_rst = src.pin || src.retention;
        if (src.selectable_supply_monitor || src.retention)
            nxt.powered = 1'b0;
        case (r.state)
            rsc_pkg::ST_RESET: begin
                nxt.cnt = 18'h0_0000;
                if (!(src.pin || src.selectable_supply_monitor || src.retention)) begin
                    nxt.state   = r.powered ? rsc_pkg::ST_PROC : rsc_pkg::ST_SPORWT;
                    nxt.powered = 1'b1;
                end
            end
            rsc_pkg::ST_SPORWT: begin
                nxt.cnt = r.cnt + 18'h0_0001;
                if (r.cnt >= SELECTABLE_SUPPLY_MONITOR_WAIT - 18'h0_0001) begin
                    nxt.state = rsc_pkg::ST_PROC;
                    nxt.cnt   = 18'h0_0000;
                end
            end
            rsc_pkg::ST_PROC: begin
                nxt.cnt = r.cnt + 18'h0_0001;
                if (r.cnt >= PROC_WAIT - 18'h0_0001) begin
                    nxt.state = rsc_pkg::ST_RUN;
                    nxt.cnt   = 18'h0_0000;
                end
            end
            rsc_pkg::ST_RUN: begin
                nxt.cnt = 18'h0_0000;
            end
            default: begin
                nxt.state = rsc_pkg::ST_RESET;
            end
        endcase
        // any enabled source restarts the sequence
        if (src.pin || src.wdt || src.trap || src.selectable_supply_monitor || src.retention)
            nxt.state = rsc_pkg::ST_RESET;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r.state     <= rsc_pkg::ST_RESET;
            r.cnt       <= 18'h0_0000;
            r.trap_flag <= 1'b0;
            r.wdt_flag  <= 1'b0;
            r.selectable_supply_monitor_flag <= 1'b0;
            r.pin_rst   <= 1'b0;
            r.powered   <= 1'b0;
            r.rdata     <= 8'h00;
        end else begin
            r <= nxt;
        end
    end

    // ==========================================
    // outputs
    logic in_reset;
    assign in_reset = r.state != rsc_pkg::ST_RUN;

    assign rd_data            = r.rdata;
    assign sys_reset          = in_reset;
    assign cpu_clk_en         = r.state == rsc_pkg::ST_RUN;
    // oscillator only runs once processing starts; it clocks the program afterwards
    assign osc_en             = r.state == rsc_pkg::ST_PROC || r.state == rsc_pkg::ST_RUN;
    assign crystal_pins_input = in_reset;
    assign ports_float        = in_reset;
    // pc is only loaded on entry to run; nothing else is disturbed
    assign pc_load            = r.state == rsc_pkg::ST_PROC && r.cnt == PROC_WAIT - 18'h0_0001;
    assign pc_vector          = `RSC_VECTOR_ADDR;
    assign psw_init           = `RSC_PSW_RESET;
    assign port4_bit0_oe      = 1'b0;
    assign port4_bit0_pullup  = !(in_reset && r.pin_rst);
    assign port12_bit5_low    = in_reset && r.pin_rst && !pin_s2_r[1];
    assign port12_bit5_pullup = !port12_bit5_low;

    // ==========================================
    // checks
    sequence s_read_flags;
        flags_read;
    endsequence

    a_read_clears: assert property (@(posedge clk) disable iff (!rst_n)
        s_read_flags and (!src.trap && !src.wdt && !(src.selectable_supply_monitor && r.powered))
        |=> !r.trap_flag && !r.wdt_flag && !r.selectable_supply_monitor_flag)
        else $error("flag read did not clear flags");
    a_read_layout: assert property (@(posedge clk) disable iff (!rst_n)
        s_read_flags |=> rd_data == {$past(r.trap_flag), 2'b00, $past(r.wdt_flag), 3'b000, $past(r.selectable_supply_monitor_flag)})
        else $error("flag layout wrong");
    a_trap_sets: assert property (@(posedge clk) disable iff (!rst_n)
        src.trap && !src.pin && !src.retention |=> r.trap_flag && sys_reset)
        else $error("illegal opcode not flagged");
    a_trap_debug: assert property (@(posedge clk) disable iff (!rst_n)
        debug_active && r.state == rsc_pkg::ST_RUN && !src.wdt && !src.pin && !src.selectable_supply_monitor && !src.retention
        |=> !sys_reset)
        else $error("trap reset issued under debug");
    a_wdt_keeps: assert property (@(posedge clk) disable iff (!rst_n)
        src.wdt && !src.pin && !src.retention && !flags_read && !src.selectable_supply_monitor && !src.trap
        |=> r.wdt_flag && r.trap_flag == $past(r.trap_flag) && r.selectable_supply_monitor_flag == $past(r.selectable_supply_monitor_flag))
        else $error("watchdog flag update wrong");
    a_pin_clears: assert property (@(posedge clk) disable iff (!rst_n)
        src.pin |=> !r.trap_flag && !r.wdt_flag && !r.selectable_supply_monitor_flag)
        else $error("pin reset did not clear flags");
    a_auto_release: assert property (@(posedge clk) disable iff (!rst_n)
        r.state == rsc_pkg::ST_PROC && r.cnt == 18'h0_0000 && !src.pin && !src.selectable_supply_monitor && !src.retention
        ##1 (!src.pin && !src.selectable_supply_monitor && !src.retention && !src.wdt && !src.trap) [*8]
        |-> ##8 (r.state == rsc_pkg::ST_RUN || src.pin || src.selectable_supply_monitor || src.retention))
        else $error("processing did not release");
    a_clk_gated: assert property (@(posedge clk) disable iff (!rst_n)
        sys_reset |-> !cpu_clk_en && crystal_pins_input && ports_float)
        else $error("clock not gated in reset");

    // ==========================================
    // checks on release, pins and the flag byte
    localparam int SELECTABLE_SUPPLY_MONITOR_WAIT_LIMIT = `RSC_SELECTABLE_SUPPLY_MONITOR_WAIT_NS / (1000000000 / `RSC_CLK_HZ);

    sequence s_src_quiet;
        !src.pin && !src.selectable_supply_monitor && !src.retention;
    endsequence

    sequence s_reset_entry;
        r.state != rsc_pkg::ST_RESET ##1 r.state == rsc_pkg::ST_RESET;
    endsequence

    sequence s_proc_exit;
        pc_load ##1 r.state == rsc_pkg::ST_RUN;
    endsequence

    a_selectable_supply_monitor_sets: assert property (@(posedge clk) disable iff (!rst_n)
        src.selectable_supply_monitor && r.powered && !src.pin && !src.retention |=> r.selectable_supply_monitor_flag && sys_reset)
        else $error("supply monitor reset not flagged");
    a_selectable_supply_monitor_keeps: assert property (@(posedge clk) disable iff (!rst_n)
        src.selectable_supply_monitor && r.powered && !src.pin && !src.retention && !src.trap && !src.wdt && !flags_read
        |=> r.trap_flag == $past(r.trap_flag) && r.wdt_flag == $past(r.wdt_flag))
        else $error("supply monitor reset disturbed other flags");
    a_trap_keeps: assert property (@(posedge clk) disable iff (!rst_n)
        src.trap && !src.wdt && !src.selectable_supply_monitor && !src.pin && !src.retention && !flags_read
        |=> r.wdt_flag == $past(r.wdt_flag) && r.selectable_supply_monitor_flag == $past(r.selectable_supply_monitor_flag))
        else $error("illegal opcode reset disturbed other flags");
    a_ret_clears: assert property (@(posedge clk) disable iff (!rst_n)
        src.retention |=> !r.trap_flag && !r.wdt_flag && !r.selectable_supply_monitor_flag)
        else $error("retention reset did not clear flags");
    a_flag_kept: assert property (@(posedge clk) disable iff (!rst_n)
        !flags_read && !src.pin && !src.retention
        |=> (!$past(r.trap_flag) || r.trap_flag) && (!$past(r.wdt_flag) || r.wdt_flag)
            && (!$past(r.selectable_supply_monitor_flag) || r.selectable_supply_monitor_flag))
        else $error("flag lost without clear");
    a_bit_refused: assert property (@(posedge clk) disable iff (!rst_n)
        rd_en && (rd_bit_access || rd_addr != `RSC_FLAGS_ADDR) |=> rd_data == 8'h00)
        else $error("refused read returned data");
    a_read_idle: assert property (@(posedge clk) disable iff (!rst_n)
        !flags_read |=> rd_data == 8'h00)
        else $error("read data stood too long");
    a_entry_gates: assert property (@(posedge clk) disable iff (!rst_n)
        s_reset_entry |-> !cpu_clk_en && !osc_en && ports_float)
        else $error("reset entry left clocks running");
    a_osc_reset: assert property (@(posedge clk) disable iff (!rst_n)
        r.state == rsc_pkg::ST_RESET |-> !osc_en && !cpu_clk_en)
        else $error("oscillator running in reset");
    a_pc_run: assert property (@(posedge clk) disable iff (!rst_n)
        pc_load ##0 s_src_quiet |-> s_proc_exit)
        else $error("pc load not followed by run");
    a_pc_once: assert property (@(posedge clk) disable iff (!rst_n)
        pc_load |=> !pc_load)
        else $error("pc loaded twice");
    a_run_pins: assert property (@(posedge clk) disable iff (!rst_n)
        !sys_reset |-> cpu_clk_en && osc_en && port4_bit0_pullup && port12_bit5_pullup && !port4_bit0_oe)
        else $error("running state pins wrong");
    a_pin_float: assert property (@(posedge clk) disable iff (!rst_n)
        sys_reset && r.pin_rst |-> !port4_bit0_pullup && !port4_bit0_oe)
        else $error("port4_bit0 not floating");
    a_p12_low: assert property (@(posedge clk) disable iff (!rst_n)
        port12_bit5_low |-> sys_reset && r.pin_rst && !port12_bit5_pullup)
        else $error("port12_bit5 low outside pin reset");
    a_selectable_supply_monitor_wait: assert property (@(posedge clk) disable iff (!rst_n)
        r.state == rsc_pkg::ST_SPORWT |-> r.cnt < SELECTABLE_SUPPLY_MONITOR_WAIT)
        else $error("supply monitor wait overran");
    a_wait_bound: assert property (@(posedge clk) disable iff (!rst_n)
        r.state == rsc_pkg::ST_SPORWT |-> int'(r.cnt) < SELECTABLE_SUPPLY_MONITOR_WAIT_LIMIT)
        else $error("supply monitor wait beyond ceiling");
    a_proc_len: assert property (@(posedge clk) disable iff (!rst_n)
        r.state == rsc_pkg::ST_PROC |-> r.cnt < PROC_WAIT)
        else $error("processing overran");
    a_mon_active: assert property (@(posedge clk) disable iff (!rst_n)
        sys_reset && src.selectable_supply_monitor && !src.pin && !src.retention |=> r.state == rsc_pkg::ST_RESET)
        else $error("supply monitor ignored in reset");
    a_wdt_reset: assert property (@(posedge clk) disable iff (!rst_n)
        src.wdt |=> r.state == rsc_pkg::ST_RESET && sys_reset)
        else $error("watchdog did not reset");
    a_pin_reset: assert property (@(posedge clk) disable iff (!rst_n)
        src.pin |=> r.state == rsc_pkg::ST_RESET && sys_reset)
        else $error("pin did not reset");
    a_ret_reset: assert property (@(posedge clk) disable iff (!rst_n)
        src.retention |=> sys_reset && !r.powered)
        else $error("retention did not reset");
    a_pinsel_off: assert property (@(posedge clk) disable iff (!rst_n)
        !config_byte[`RSC_CFG_PINSEL_BIT] && r.state == rsc_pkg::ST_RUN && !src.selectable_supply_monitor && !src.retention
        && !src.wdt && !src.trap |=> !sys_reset)
        else $error("pin reset while pin not selected");
    a_run_powered: assert property (@(posedge clk) disable iff (!rst_n)
        r.state == rsc_pkg::ST_RUN |-> r.powered)
        else $error("running below threshold");

endmodule // rsc_reset_source_controller

// >>> rsc_supply_model.sv
// reset pin driver and supply comparator bank facing the reset source controller
module rsc_supply_model #(
    parameter logic [12:0] RETENTION_MV = 13'h0640
) (
    // bench commands
    input  wire logic [12:0] vdd_mv,
    input  wire logic        pin_hold,
    // device side
    output logic             reset_pin_n,
    output logic [3:0]       vdd_above_rise,
    output logic [3:0]       vdd_above_fall,
    output logic             vdd_retention_ok
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // thresholds in millivolts, index is the threshold code
    localparam logic [12:0] RISE_MV [4] = '{13'h10b8, 13'h0b54, 13'h0a0a, 13'h0870};
    localparam logic [12:0] FALL_MV [4] = '{13'h1068, 13'h0b18, 13'h09d8, 13'h083e};

    always_comb begin
        // released pin is pulled up, never left at its last driven level
        reset_pin_n = !pin_hold;
        for (int i = 0; i < 4; i++) begin
            vdd_above_rise[i] = (vdd_mv >= RISE_MV[i]);
            vdd_above_fall[i] = (vdd_mv >= FALL_MV[i]);
        end
        vdd_retention_ok = (vdd_mv >= RETENTION_MV);
    end
endmodule // rsc_supply_model

// >>> rsc_testbench.sv
// self-checking bench of the reset source controller
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // signals
    logic        clk, rst_n, pin_hold, wdt_overflow, exec_valid, debug_active, rd_en, rd_bit_access;
    logic        reset_pin_n, vdd_retention_ok, sys_reset, cpu_clk_en, osc_en, crystal_pins_input;
    logic        ports_float, pc_load, port4_bit0_pullup, port4_bit0_oe, port12_bit5_pullup, port12_bit5_low;
    logic [3:0]  vdd_above_rise, vdd_above_fall;
    logic [7:0]  config_byte, exec_opcode, rd_data, psw_init;
    logic [12:0] vdd_mv;
    logic [15:0] pc_vector;
    logic [19:0] rd_addr;
    int          fail_count = 0;
    int          compares = 0;
    int          pc_loads = 0;
    localparam logic [19:0] FLAGS = 20'hf_ffa8;
    localparam logic [12:0] VDD_OK = 13'h1388;
    // levels that sit just under the falling threshold of codes 00..11
    localparam logic [12:0] LOW_MV [4] = '{13'h0fa0, 13'h0af0, 13'h09c4, 13'h0820};

    rsc_supply_model rsc_supply_model_inst (.vdd_mv(vdd_mv), .pin_hold(pin_hold), .reset_pin_n(reset_pin_n),
        .vdd_above_rise(vdd_above_rise), .vdd_above_fall(vdd_above_fall), .vdd_retention_ok(vdd_retention_ok));
    rsc_reset_source_controller rsc_reset_source_controller_inst (.clk(clk), .rst_n(rst_n),
        .reset_pin_n(reset_pin_n), .vdd_above_rise(vdd_above_rise), .vdd_above_fall(vdd_above_fall),
        .vdd_retention_ok(vdd_retention_ok), .config_byte(config_byte), .wdt_overflow(wdt_overflow),
        .exec_opcode(exec_opcode), .exec_valid(exec_valid), .debug_active(debug_active), .rd_en(rd_en),
        .rd_bit_access(rd_bit_access), .rd_addr(rd_addr), .rd_data(rd_data), .sys_reset(sys_reset),
        .cpu_clk_en(cpu_clk_en), .osc_en(osc_en), .crystal_pins_input(crystal_pins_input),
        .ports_float(ports_float), .pc_load(pc_load), .pc_vector(pc_vector), .psw_init(psw_init),
        .port4_bit0_pullup(port4_bit0_pullup), .port4_bit0_oe(port4_bit0_oe),
        .port12_bit5_pullup(port12_bit5_pullup), .port12_bit5_low(port12_bit5_low));

    always #10 clk = ~clk;
    always @(posedge clk) if (pc_load === 1'b1) pc_loads++;

    // ==========================================
    // shared tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic wait_reset(input logic level, input int limit);
        int n;
        n = 0;
        while (sys_reset !== level && n < limit) begin
            tick(1);
            n++;
        end
        check(sys_reset, level);
    endtask
    task automatic read_flags(input logic [19:0] addr, input logic bit_acc, input logic [7:0] exp);
        rd_addr = addr;
        rd_bit_access = bit_acc;
        rd_en = 1'b1;
        tick(1);
        rd_en = 1'b0;
        check(rd_data, exp);
        tick(1);
        check(rd_data, 8'h00);
    endtask
    // one-cycle opcode; a reset, when expected, is seen on the next cycle
    task automatic execute(input logic [7:0] op, input logic dbg, input logic exp_rst);
        exec_opcode = op;
        debug_active = dbg;
        exec_valid = 1'b1;
        tick(1);
        exec_valid = 1'b0;
        debug_active = 1'b0;
        check(sys_reset, exp_rst);
        wait_reset(1'b0, 40);
        tick(1);
    endtask
    task automatic wdt_pulse();
        wdt_overflow = 1'b1;
        tick(1);
        wdt_overflow = 1'b0;
        check({sys_reset, cpu_clk_en, osc_en, ports_float, crystal_pins_input, port4_bit0_pullup,
            port12_bit5_low}, 16'h004e);
        wait_reset(1'b0, 40);
    endtask
    task automatic check_running();
        check({cpu_clk_en, osc_en, ports_float, crystal_pins_input, port4_bit0_pullup, port12_bit5_pullup,
            port4_bit0_oe}, 16'h0066);
        check(pc_vector, 16'h0000);
        check({8'h00, psw_init}, 16'h0006);
    endtask

    // ==========================================
    // scenarios
    task automatic test_power_up();
        tick(4);
        check(sys_reset, 1'b1);
        wait_reset(1'b0, 151000);
        check(16'(pc_loads), 16'h0001);
        check_running();
        read_flags(FLAGS, 1'b0, 8'h00);
    endtask
    task automatic test_wdt_trap();
        wdt_pulse();
        execute(8'hfe, 1'b0, 1'b0);
        execute(8'hff, 1'b1, 1'b0);
        execute(8'hff, 1'b0, 1'b1);
        check_running();
        read_flags(FLAGS, 1'b0, 8'h90);
        read_flags(FLAGS, 1'b0, 8'h00);
        wdt_pulse();
        read_flags(FLAGS, 1'b1, 8'h00);
        read_flags(20'hf_ffa9, 1'b0, 8'h00);
        read_flags(FLAGS, 1'b0, 8'h10);
    endtask
    task automatic test_thresholds();
        wdt_pulse();
        for (int c = 0; c < 4; c++) begin
            config_byte = 8'he3 | 8'(c << 2);
            vdd_mv = (c == 0) ? VDD_OK : LOW_MV[c - 1];
            tick(8);
            check(sys_reset, 1'b0);
            vdd_mv = LOW_MV[c];
            tick(8);
            check({sys_reset, port4_bit0_pullup, port12_bit5_low}, 16'h0006);
            vdd_mv = VDD_OK;
            wait_reset(1'b0, 2100);
        end
        read_flags(FLAGS, 1'b0, 8'h11);
    endtask
    task automatic test_pin_retention();
        wdt_pulse();
        config_byte = 8'he3;
        pin_hold = 1'b1;
        tick(8);
        check(sys_reset, 1'b0);
        config_byte = 8'hf3;
        tick(30);
        check({sys_reset, port4_bit0_pullup, port12_bit5_low, port12_bit5_pullup}, 16'h000a);
        pin_hold = 1'b0;
        wait_reset(1'b0, 151000);
        read_flags(FLAGS, 1'b0, 8'h00);
        wdt_pulse();
        vdd_mv = 13'h03e8;
        tick(8);
        check({sys_reset, port4_bit0_pullup}, 16'h0002);
        vdd_mv = VDD_OK;
        wait_reset(1'b0, 151000);
        read_flags(FLAGS, 1'b0, 8'h00);
    endtask

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ==========================================
    // sequence and watchdog
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        pin_hold = 1'b0;
        vdd_mv = VDD_OK;
        config_byte = 8'he3;
        wdt_overflow = 1'b0;
        exec_opcode = 8'h00;
        exec_valid = 1'b0;
        debug_active = 1'b0;
        rd_en = 1'b0;
        rd_bit_access = 1'b0;
        rd_addr = FLAGS;
        tick(5);
        rst_n = 1'b1;
        test_power_up();
        test_wdt_trap();
        test_thresholds();
        test_pin_retention();
        end_of_test();
    end
    // six supply-monitor waits plus short resets fit well inside this span
    initial begin
        #1_000_000;
        fail_count++;
        end_of_test();
    end
endmodule // testbench
